//--- rtl/spl_pkg.sv
// constants shared by the sector protection and lock logic
package spl_pkg;

  localparam int          NUM_SECTORS      = 16;
  localparam int          SECTOR_IDX_W     = 4;
  localparam int          ADDR_W           = 24;
  localparam int          SECTOR_MSB       = 19;
  localparam int          SECTOR_LSB       = 16;

  localparam logic [7:0]  OP_READ_PROT     = 8'h3C;
  localparam logic [7:0]  OP_PROTECT       = 8'h36;
  localparam logic [7:0]  OP_UNPROTECT     = 8'h39;
  localparam logic [7:0]  OP_WRITE_STATUS  = 8'h01;

  localparam logic [4:0]  OPCODE_LAST_BIT  = 5'h07;
  localparam logic [4:0]  ADDR_LAST_BIT    = 5'h17;
  localparam logic [4:0]  DATA_LAST_BIT    = 5'h07;

  // first status byte field positions
  localparam int          ST_LOCK_BIT      = 7;
  localparam int          ST_WP_BIT        = 4;
  localparam int          ST_SUM_LSB       = 2;
  localparam int          ST_GLOBAL_MSB    = 5;
  localparam int          ST_GLOBAL_LSB    = 2;

  localparam logic [3:0]  GLOBAL_UNPROTECT = 4'h0;
  localparam logic [3:0]  GLOBAL_PROTECT   = 4'hF;

  localparam logic [1:0]  SUM_NONE         = 2'h0;
  localparam logic [1:0]  SUM_SOME         = 2'h1;
  localparam logic [1:0]  SUM_ALL          = 2'h3;

  localparam logic [15:0] PROT_RESET       = 16'hFFFF;
  localparam logic        LOCK_RESET       = 1'b0;

  localparam int          SYNC_W           = 4;
  // pin levels held during reset: wp_n, si, sck, cs_n
  localparam logic [3:0]  SYNC_INIT        = 4'hD;

endpackage

//--- rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
  import spl_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input  wire logic         i_core_clk,  // core clock
  input  wire logic         i_reset,     // sync reset, high
  input  wire logic [W-1:0] i_pins,      // raw pin levels
  input  wire logic [W-1:0] i_init,      // level held during reset
  output logic      [W-1:0] o_pins       // filtered levels
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // a change counts once stages two and three agree
      always_comb begin
        out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    s1_reg <= i_pins;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (i_reset) begin
      out_reg <= i_init;
    end else begin
      out_reg <= out_next;
    end
  end

  assign o_pins = out_reg;

endmodule

//--- rtl/sector_prot_store.sv
// per-sector protection bits and the protection lock bit
`timescale 1ns/1ps
module sector_prot_store
  import spl_pkg::*;
(
  input  wire logic                    i_core_clk,     // core clock
  input  wire logic                    i_reset,        // sync reset, high
  input  wire logic                    i_wp_n,         // filtered write-protect pin
  input  wire logic                    i_cmd_protect,  // protect one sector, pulse
  input  wire logic                    i_cmd_unprot,   // unprotect one sector, pulse
  input  wire logic                    i_cmd_wrsr,     // status byte write, pulse
  input  wire logic [SECTOR_IDX_W-1:0] i_sector,       // sector index
  input  wire logic [7:0]              i_wr_data,      // written status byte
  output logic      [NUM_SECTORS-1:0]  o_prot,         // protection bits
  output logic                         o_lock,         // protection_lock_bit
  output logic                         o_hw_lock       // hardware lock active
);

  logic [NUM_SECTORS-1:0] prot_reg;
  logic [NUM_SECTORS-1:0] prot_next;
  logic                   lock_reg;
  logic                   lock_next;
  logic                   hw_lock;
  logic [3:0]             global_code;

  assign hw_lock     = !i_wp_n && lock_reg;
  assign global_code = i_wr_data[ST_GLOBAL_MSB:ST_GLOBAL_LSB];

  always_comb begin
    prot_next = prot_reg;
    lock_next = lock_reg;
    if (!hw_lock) begin
      if (!lock_reg && i_cmd_protect) begin
        prot_next[i_sector] = 1'b1;
      end
      if (!lock_reg && i_cmd_unprot) begin
        prot_next[i_sector] = 1'b0;
      end
      if (i_cmd_wrsr) begin
        lock_next = i_wr_data[ST_LOCK_BIT];
        // globals only when the lock bit was clear before this write
        if (!lock_reg) begin
          if (global_code == GLOBAL_UNPROTECT) begin
            prot_next = '0;
          end else if (global_code == GLOBAL_PROTECT) begin
            prot_next = '1;
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      prot_reg <= PROT_RESET;
      lock_reg <= LOCK_RESET;
    end else begin
      prot_reg <= prot_next;
      lock_reg <= lock_next;
    end
  end

  assign o_prot    = prot_reg;
  assign o_lock    = lock_reg;
  assign o_hw_lock = hw_lock;

endmodule

//--- rtl/sector_protect_lock_logic.sv
// serial command front end for sector protection read-back and locking
// Notes on behaviour
// - opcode 3Ch plus three address bytes selects a sector for protection read-back.
// - after the last address bit, output repeats FFh if protected, else 00h.
// - read-back shows only the stored sector bit, never the write-protect pin.
// - chip select high at any time ends read-back and releases the output.
// - summary bits report whether all, some or none of the sectors are protected.
// - write-protect pin changes nothing directly, it feeds only the hardware lock and status bit four.
// - hardware lock is active when write-protect is low and lock bit is one.
// - under hardware lock, sector bits and lock bit freeze; protect, unprotect and status writes ignored.
// - a status write made while the lock bit is set performs no global operation.
// - reset leaves all sectors protected and the lock bit cleared.
// - with write-protect high the lock bit can still be set as a software lock.
// - a status write setting the lock bit may apply global protect or unprotect.
// - a sector is protected when its bit is one, whatever the pin level.
// - under software lock the lock bit may clear; sector changes refused.
// - with lock bit clear, sector commands and globals work and lock may set.
// - lock clear: writing 00h unprotects all, 7Fh protects all, lock stays zero.
// - a status write stores only bit seven; bits five to two are decoded only.
// - status read shows pin state and summary in bits four to two.
`timescale 1ns/1ps
module sector_protect_lock_logic
  import spl_pkg::*;
(
  input  wire logic                   i_core_clk,                 // core clock, 125 MHz
  input  wire logic                   i_reset,                    // sync reset, high
  input  wire logic                   i_cs_n,                     // chip select, low active
  input  wire logic                   i_sck,                      // serial clock pin
  input  wire logic                   i_si,                       // serial data in
  input  wire logic                   i_wp_n,                     // write-protect pin, low active
  output logic                        o_so,                       // serial data out
  output logic                        o_so_oe,                    // serial out enable
  output logic                        o_protection_lock_bit,      // lock bit
  output logic                        o_hw_lock,                  // hardware lock active
  output logic [1:0]                  o_software_protect_summary, // none/some/all
  output logic [7:0]                  o_status_byte1,             // first status byte image
  output logic [NUM_SECTORS-1:0]      o_sector_prot               // protection bits
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_READBACK,
    ST_ARMED,
    ST_IGNORE
  } cmd_state_t;

  typedef enum logic [1:0] {
    KIND_READ,
    KIND_PROT,
    KIND_UNPROT,
    KIND_WRSR
  } cmd_kind_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic [SYNC_W-1:0] pins_f;
  logic              cs_n_f;
  logic              sck_f;
  logic              si_f;
  logic              wp_n_f;
  logic              sck_prev_reg;
  logic              cs_n_prev_reg;
  logic              sck_rise;
  logic              cs_fall;
  logic              cs_rise;

  pin_sync #(
    .W          (SYNC_W)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pins     ({i_wp_n, i_si, i_sck, i_cs_n}),
    .i_init     (SYNC_INIT),
    .o_pins     (pins_f)
  );

  assign cs_n_f   = pins_f[0];
  assign sck_f    = pins_f[1];
  assign si_f     = pins_f[2];
  assign wp_n_f   = pins_f[3];
  assign sck_rise = sck_f && !sck_prev_reg;
  assign cs_fall  = !cs_n_f && cs_n_prev_reg;
  assign cs_rise  = cs_n_f && !cs_n_prev_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sck_prev_reg  <= SYNC_INIT[1];
      cs_n_prev_reg <= SYNC_INIT[0];
    end else begin
      sck_prev_reg  <= sck_f;
      cs_n_prev_reg <= cs_n_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decoder

  cmd_state_t               state_reg;
  cmd_state_t               state_next;
  cmd_kind_t                kind_reg;
  cmd_kind_t                kind_next;
  logic [4:0]               cnt_reg;
  logic [4:0]               cnt_next;
  logic [ADDR_W-1:0]        shift_reg;
  logic [ADDR_W-1:0]        shift_next;
  logic [SECTOR_IDX_W-1:0]  sector_reg;
  logic [SECTOR_IDX_W-1:0]  sector_next;
  logic [7:0]               wdata_reg;
  logic [7:0]               wdata_next;
  logic                     so_reg;
  logic                     so_next;
  logic                     oe_reg;
  logic                     oe_next;
  logic                     cmd_prot_reg;
  logic                     cmd_prot_next;
  logic                     cmd_unprot_reg;
  logic                     cmd_unprot_next;
  logic                     cmd_wrsr_reg;
  logic                     cmd_wrsr_next;
  logic [ADDR_W-1:0]        shifted;
  logic [NUM_SECTORS-1:0]   prot;
  logic                     lock_bit;
  logic                     hw_lock;

  assign shifted = {shift_reg[ADDR_W-2:0], si_f};

  always_comb begin
    state_next      = state_reg;
    kind_next       = kind_reg;
    cnt_next        = cnt_reg;
    shift_next      = shift_reg;
    sector_next     = sector_reg;
    wdata_next      = wdata_reg;
    so_next         = so_reg;
    oe_next         = oe_reg;
    cmd_prot_next   = 1'b0;
    cmd_unprot_next = 1'b0;
    cmd_wrsr_next   = 1'b0;
    if (cs_n_f) begin
      // deselect ends any command and releases the output
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      so_next    = 1'b0;
      if (cs_rise && state_reg == ST_ARMED) begin
        cmd_prot_next   = (kind_reg == KIND_PROT);
        cmd_unprot_next = (kind_reg == KIND_UNPROT);
        cmd_wrsr_next   = (kind_reg == KIND_WRSR);
      end
    end else if (cs_fall) begin
      state_next = ST_OPCODE;
      cnt_next   = '0;
      shift_next = '0;
    end else if (sck_rise) begin
      shift_next = shifted;
      cnt_next   = cnt_reg + 5'h01;
      case (state_reg)
        ST_OPCODE: begin
          if (cnt_reg == OPCODE_LAST_BIT) begin
            cnt_next   = '0;
            state_next = ST_ADDR;
            case (shifted[7:0])
              OP_READ_PROT:    kind_next = KIND_READ;
              OP_PROTECT:      kind_next = KIND_PROT;
              OP_UNPROTECT:    kind_next = KIND_UNPROT;
              OP_WRITE_STATUS: begin
                kind_next  = KIND_WRSR;
                state_next = ST_DATA;
              end
              default:         state_next = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          if (cnt_reg == ADDR_LAST_BIT) begin
            cnt_next    = '0;
            sector_next = shifted[SECTOR_MSB:SECTOR_LSB];
            if (kind_reg == KIND_READ) begin
              state_next = ST_READBACK;
              // stored bit only; pin level plays no part
              so_next    = prot[shifted[SECTOR_MSB:SECTOR_LSB]];
              oe_next    = 1'b1;
            end else begin
              state_next = ST_ARMED;
            end
          end
        end
        ST_DATA: begin
          if (cnt_reg == DATA_LAST_BIT) begin
            cnt_next   = '0;
            wdata_next = shifted[7:0];
            state_next = ST_ARMED;
          end
        end
        ST_READBACK: begin
          so_next = prot[sector_reg];
          oe_next = 1'b1;
        end
        ST_ARMED: begin
          // clocks past the byte boundary abort the command
          state_next = ST_IGNORE;
        end
        ST_IDLE, ST_IGNORE: begin
          cnt_next = cnt_reg;
        end
        default: state_next = ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg      <= ST_IDLE;
      kind_reg       <= KIND_READ;
      cnt_reg        <= '0;
      shift_reg      <= '0;
      sector_reg     <= '0;
      wdata_reg      <= '0;
      so_reg         <= 1'b0;
      oe_reg         <= 1'b0;
      cmd_prot_reg   <= 1'b0;
      cmd_unprot_reg <= 1'b0;
      cmd_wrsr_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      kind_reg       <= kind_next;
      cnt_reg        <= cnt_next;
      shift_reg      <= shift_next;
      sector_reg     <= sector_next;
      wdata_reg      <= wdata_next;
      so_reg         <= so_next;
      oe_reg         <= oe_next;
      cmd_prot_reg   <= cmd_prot_next;
      cmd_unprot_reg <= cmd_unprot_next;
      cmd_wrsr_reg   <= cmd_wrsr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection store

  sector_prot_store u_store (
    .i_core_clk    (i_core_clk),
    .i_reset       (i_reset),
    .i_wp_n        (wp_n_f),
    .i_cmd_protect (cmd_prot_reg),
    .i_cmd_unprot  (cmd_unprot_reg),
    .i_cmd_wrsr    (cmd_wrsr_reg),
    .i_sector      (sector_reg),
    .i_wr_data     (wdata_reg),
    .o_prot        (prot),
    .o_lock        (lock_bit),
    .o_hw_lock     (hw_lock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status outputs

  logic [1:0] sum_reg;
  logic [1:0] sum_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic       hwl_reg;
  logic       lockq_reg;
  logic [NUM_SECTORS-1:0] protq_reg;

  always_comb begin
    if (&prot) begin
      sum_next = SUM_ALL;
    end else if (|prot) begin
      sum_next = SUM_SOME;
    end else begin
      sum_next = SUM_NONE;
    end
    status_next                          = '0;
    status_next[ST_LOCK_BIT]             = lock_bit;
    status_next[ST_WP_BIT]               = wp_n_f;
    status_next[ST_SUM_LSB+1:ST_SUM_LSB] = sum_next;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sum_reg    <= SUM_ALL;
      status_reg <= '0;
      hwl_reg    <= 1'b0;
      lockq_reg  <= LOCK_RESET;
      protq_reg  <= PROT_RESET;
    end else begin
      sum_reg    <= sum_next;
      status_reg <= status_next;
      hwl_reg    <= hw_lock;
      lockq_reg  <= lock_bit;
      protq_reg  <= prot;
    end
  end

  assign o_so                       = so_reg;
  assign o_so_oe                    = oe_reg;
  assign o_protection_lock_bit      = lockq_reg;
  assign o_hw_lock                  = hwl_reg;
  assign o_software_protect_summary = sum_reg;
  assign o_status_byte1             = status_reg;
  assign o_sector_prot              = protq_reg;

endmodule

//--- bench/sector_protect_lock_logic_asserts.sv
// concurrent checks on the sector protection front end ports
`timescale 1ns/1ps
module sector_protect_lock_logic_asserts
  import spl_pkg::*;
(
  input wire logic                   i_core_clk,                 // core clock
  input wire logic                   i_reset,                    // sync reset
  input wire logic                   i_cs_n,                     // chip select
  input wire logic                   i_sck,                      // serial clock
  input wire logic                   i_si,                       // serial in
  input wire logic                   i_wp_n,                     // write-protect pin
  input wire logic                   o_so,                       // serial out
  input wire logic                   o_so_oe,                    // serial out enable
  input wire logic                   o_protection_lock_bit,      // lock bit
  input wire logic                   o_hw_lock,                  // hardware lock
  input wire logic [1:0]             o_software_protect_summary, // summary
  input wire logic [7:0]             o_status_byte1,             // status image
  input wire logic [NUM_SECTORS-1:0] o_sector_prot               // protection bits
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  function automatic logic [1:0] exp_sum(input logic [NUM_SECTORS-1:0] p);
    return (&p) ? 2'h3 : ((|p) ? 2'h1 : 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  property p_summary; $stable(o_sector_prot) [*3] |-> o_software_protect_summary == exp_sum(o_sector_prot); endproperty
  property p_status_fields;
    $stable(o_software_protect_summary) [*3] |->
      o_status_byte1[3:2] == o_software_protect_summary && o_status_byte1[6:5] == 2'h0 && o_status_byte1[1:0] == 2'h0;
  endproperty
  property p_lock_mirror; $stable(o_protection_lock_bit) [*3] |-> o_status_byte1[7] == o_protection_lock_bit; endproperty
  property p_hw_on; (o_protection_lock_bit && !o_status_byte1[4]) [*4] |-> o_hw_lock; endproperty
  property p_hw_off; (!o_protection_lock_bit || o_status_byte1[4]) [*4] |-> !o_hw_lock; endproperty
  property p_freeze; o_hw_lock [*4] |-> $stable(o_sector_prot) && $stable(o_protection_lock_bit); endproperty
  property p_prot_quiet; $changed(o_sector_prot) |-> $past(i_cs_n, 3) && !$past(i_cs_n, 14); endproperty
  property p_so_release; $rose(i_cs_n) |-> ##[1:8] !o_so_oe; endproperty
  property p_so_idle; i_cs_n [*8] |-> !o_so_oe && !o_so; endproperty
  property p_so_steady; o_so_oe && $past(o_so_oe) |-> $stable(o_so); endproperty
  property p_oe_selected; $rose(o_so_oe) |-> !i_cs_n && !$past(i_cs_n, 4); endproperty

  a_summary: assert property (p_summary) else $error("summary disagrees with protection bits");
  a_status_fields: assert property (p_status_fields) else $error("status byte fields wrong");
  a_lock_mirror: assert property (p_lock_mirror) else $error("status bit seven not lock bit");
  a_hw_on: assert property (p_hw_on) else $error("hardware lock missing");
  a_hw_off: assert property (p_hw_off) else $error("hardware lock without cause");
  a_freeze: assert property (p_freeze) else $error("state moved under hardware lock");
  a_prot_quiet: assert property (p_prot_quiet) else $error("protection changed outside frame end");
  a_so_release: assert property (p_so_release) else $error("serial out not released");
  a_so_idle: assert property (p_so_idle) else $error("serial out driven while deselected");
  a_so_steady: assert property (p_so_steady) else $error("read-back byte not repeating");
  a_oe_selected: assert property (p_oe_selected) else $error("read-back started unselected");

  c_readback: cover property ($rose(o_so_oe));
  c_hw_lock: cover property ($rose(o_hw_lock));
  c_some: cover property (o_software_protect_summary == SUM_SOME);
  c_none: cover property (o_software_protect_summary == SUM_NONE);
endmodule

//--- bench/spi_host_model.sv
// behavioural spi host issuing flash command frames, mode 0
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_core_clk, // paces the link
  input  wire logic i_so,       // serial data from device
  output logic      o_cs_n,     // chip select, low active
  output logic      o_sck,      // serial clock, idles low
  output logic      o_si        // serial data to device
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b1;
  end

  // half of the 64 ns link period
  task automatic half_period();
    repeat (4) @(negedge i_core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // shift nbits of word msb first, then clock in nrd bits
  task automatic frame(input logic [31:0] word, input int nbits, input int nrd, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    @(negedge i_core_clk);
    o_cs_n = 1'b0;
    for (i = 0; i < nbits + nrd; i++) begin
      o_si = (i < nbits) ? word[31-i] : ~o_si;
      half_period();
      if (i >= nbits) rd = {rd[14:0], i_so};
      o_sck = 1'b1;
      half_period();
      o_sck = 1'b0;
    end
    half_period();
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    repeat (10) @(negedge i_core_clk);
  endtask
endmodule

//--- bench/sector_protect_lock_logic_tb.sv
// self-checking bench for the sector protection front end
`timescale 1ns/1ps
module sector_protect_lock_logic_tb;
  import spl_pkg::*;
  typedef struct {
    logic        wp_n;
    logic [31:0] word;
    int          nbits;
    logic [15:0] prot;
    logic        lock;
    logic [7:0]  rd;
  } row_t;
  logic        core_clk;
  logic        reset;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        wp_n;
  logic        so;
  logic        so_oe;
  logic        so_line;
  logic        lock_bit;
  logic        hw_lock;
  logic [1:0]  sum;
  logic [7:0]  status;
  logic [15:0] prot;
  logic [15:0] rd;
  int          num_errors;
  int          comparisons;
  row_t        rows[18];

  sector_protect_lock_logic u_dut (
    .i_core_clk(core_clk), .i_reset(reset), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(wp_n),
    .o_so(so), .o_so_oe(so_oe), .o_protection_lock_bit(lock_bit), .o_hw_lock(hw_lock),
    .o_software_protect_summary(sum), .o_status_byte1(status), .o_sector_prot(prot)
  );
  // undriven line shows the inverse so a missing enable is caught
  assign so_line = so_oe ? so : ~so;
  spi_host_model u_host (.i_core_clk(core_clk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_status(input logic lk, input logic wp, input logic [15:0] p);
    return {lk, 2'h0, wp, (&p) ? 2'h3 : ((|p) ? 2'h1 : 2'h0), 2'h0};
  endfunction

  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset       = 1'b1;
    wp_n        = 1'b1;
    num_errors  = 0;
    comparisons = 0;
    rows = '{
      '{1'b1, {OP_READ_PROT, 24'h030000}, 32, 16'hFFFF, 1'b0, 8'hFF},
      '{1'b1, {OP_UNPROTECT, 24'h03ABCD}, 32, 16'hFFF7, 1'b0, 8'h00},
      '{1'b1, {OP_READ_PROT, 24'h03FFFF}, 32, 16'hFFF7, 1'b0, 8'h00},
      '{1'b0, {OP_READ_PROT, 24'h031234}, 32, 16'hFFF7, 1'b0, 8'h00},
      '{1'b0, {OP_READ_PROT, 24'h040000}, 32, 16'hFFF7, 1'b0, 8'hFF},
      '{1'b0, {OP_PROTECT, 24'h030000}, 32, 16'hFFFF, 1'b0, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'h00, 16'h0000}, 16, 16'h0000, 1'b0, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'h7F, 16'h0000}, 16, 16'hFFFF, 1'b0, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'h00, 16'h0000}, 16, 16'h0000, 1'b0, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'hFF, 16'h0000}, 16, 16'hFFFF, 1'b1, 8'h00},
      '{1'b1, {OP_UNPROTECT, 24'h000000}, 32, 16'hFFFF, 1'b1, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'h00, 16'h0000}, 16, 16'hFFFF, 1'b0, 8'h00},
      '{1'b1, {OP_UNPROTECT, 24'h050000}, 32, 16'hFFDF, 1'b0, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'hC0, 16'h0000}, 16, 16'h0000, 1'b1, 8'h00},
      '{1'b0, {OP_PROTECT, 24'h020000}, 32, 16'h0000, 1'b1, 8'h00},
      '{1'b0, {OP_WRITE_STATUS, 8'h00, 16'h0000}, 16, 16'h0000, 1'b1, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'h3C, 16'h0000}, 16, 16'h0000, 1'b0, 8'h00},
      '{1'b1, {OP_WRITE_STATUS, 8'hF0, 16'h0000}, 16, 16'h0000, 1'b1, 8'h00}
    };
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    repeat (8) @(negedge core_clk);
    foreach (rows[i]) begin
      wp_n = rows[i].wp_n;
      repeat (8) @(negedge core_clk);
      u_host.frame(rows[i].word, rows[i].nbits, (rows[i].word[31:24] == OP_READ_PROT) ? 16 : 0, rd);
      repeat (4) @(negedge core_clk);
      if (rows[i].word[31:24] == OP_READ_PROT) check(rd[7:0], rows[i].rd);
      check(prot, rows[i].prot);
      check(lock_bit, rows[i].lock);
      check(hw_lock, !wp_n && rows[i].lock);
      check(status, exp_status(rows[i].lock, wp_n, rows[i].prot));
    end
    // read abandoned three bits into the first byte
    u_host.frame({OP_READ_PROT, 24'h000000}, 32, 3, rd);
    check(rd[2:0], 3'h0);
    check({so_oe, so}, 2'h0);
    // aborted or unknown frames leave the software lock set
    u_host.frame({OP_WRITE_STATUS, 24'h000000}, 16, 1, rd);
    check(lock_bit, 1'b1);
    u_host.frame({OP_WRITE_STATUS, 24'h000000}, 12, 0, rd);
    check(lock_bit, 1'b1);
    u_host.frame({8'hFE, 24'h000000}, 16, 0, rd);
    check(lock_bit, 1'b1);
    // second reset with lock set and all sectors open
    reset = 1'b1;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    repeat (8) @(negedge core_clk);
    check(prot, 16'hFFFF);
    check(lock_bit, 1'b0);
    u_host.frame({OP_READ_PROT, 24'h0F0000}, 32, 16, rd);
    check(rd[7:0], 8'hFF);
    end_of_test();
  end
endmodule

bind sector_protect_lock_logic sector_protect_lock_logic_asserts u_asserts (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .i_wp_n(i_wp_n),
  .o_so(o_so), .o_so_oe(o_so_oe), .o_protection_lock_bit(o_protection_lock_bit), .o_hw_lock(o_hw_lock),
  .o_software_protect_summary(o_software_protect_summary), .o_status_byte1(o_status_byte1),
  .o_sector_prot(o_sector_prot)
);
